// >>> dv/adc_readout_sva.sv
// Purpose: Clock-side checks of the converter readout at its top ports.
// Assumes: Link pins reach clk through a synchroniser, so reactions lag 4 to 5 cycles.
// Notes:   The serial bit stream itself is judged by the bench.

`timescale 1ns/1ps
`default_nettype none

module adc_readout_sva
    import adc_readout_pkg::*;
(
    // System clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host link.
    input wire logic serial_clock,
    input wire logic frame_select_n,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_n,
    // Analog core.
    input wire logic comparator_high,
    input wire logic [RESULT_BITS-1:0] dac_code,
    input wire logic sample_hold,
    input wire logic analog_power_on,
    // Finished result.
    input wire logic [RESULT_BITS-1:0] result_code,
    input wire logic result_valid,
    input wire logic result_dummy
);
    // The window of 1 to 5 cycles covers the synchroniser lag; the reaction shows on its fifth cycle.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    oe_on_fall_a: assert property ($fell(frame_select_n) |-> ##[1:5] !serial_result_oe_n)
        else $error("output enable missed frame start");
    hold_on_fall_a: assert property ($fell(frame_select_n) |-> ##[1:5] sample_hold)
        else $error("hold missed frame start");
    power_on_fall_a: assert property ($fell(frame_select_n) |-> ##[1:5] analog_power_on)
        else $error("core not powered at frame start");
    oe_off_rise_a: assert property ($rose(frame_select_n) |-> ##[1:5] serial_result_oe_n)
        else $error("pin still driven after frame end");
    oe_idle_a: assert property (frame_select_n [*8] |-> serial_result_oe_n)
        else $error("pin driven while idle");
    shutdown_keep_a: assert property (!analog_power_on && frame_select_n |=> !analog_power_on)
        else $error("left shutdown without a frame");
    valid_normal_a: assert property (result_valid |-> analog_power_on && !result_dummy)
        else $error("result flagged in wrong mode");
    result_in_frame_a: assert property ($changed(result_code) |-> !frame_select_n)
        else $error("result changed outside a frame");
    trial_idle_a: assert property (frame_select_n [*4] |-> dac_code == CODE_START)
        else $error("trial code not restarted");

    // Main scenarios: a valid result, shutdown entry, a waking frame left behind.
    cover property (result_valid);
    cover property ($fell(analog_power_on));
    cover property ($fell(result_dummy));
endmodule : adc_readout_sva

bind serial_sar_adc_readout adc_readout_sva u_sva (.clk(clk), .rst_n(rst_n),
    .serial_clock(serial_clock), .frame_select_n(frame_select_n),
    .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
    .comparator_high(comparator_high), .dac_code(dac_code), .sample_hold(sample_hold),
    .analog_power_on(analog_power_on), .result_code(result_code),
    .result_valid(result_valid), .result_dummy(result_dummy));

`default_nettype wire

// >>> dv/host_link_model.sv
// Purpose: Host serial port that frames conversions and shifts in the result.
// Assumes: Serial clock idles high and runs only inside frames.
// Notes:   Frame select rises well after the last falling edge to avoid a capture race.

`timescale 1ns/1ps
`default_nettype none

module host_link_model
    import adc_readout_pkg::*;
(
    // Link clock and framing driven by the host.
    output logic serial_clock,
    output logic frame_select_n,
    // Resolved serial data line.
    input wire logic serial_result_out_line
);
    localparam int HALF_NS = 3;

    // Idle levels before the first frame. A short low pulse while reset is held gives
    // the link side a real rising edge of frame select, so it leaves the unknown state
    // even when its processes start after this block at time zero.
    initial begin
        serial_clock = 1'b1;
        frame_select_n = 1'b0;
        #1;
        frame_select_n = 1'b1;
    end

    // One frame of the given number of falling edges; captures up to sixteen bits.
    // Frame select falls with the clock high, so no extra leading zero arises.
    // Frame select falls with the clock high and the first falling edge follows 20 ns later.
    // Sixteen falls plus the track gap keep the frame at least twenty periods.
    task automatic run_frame(input int falls, output logic [15:0] bits);
        bits = 16'h0000;
        frame_select_n = 1'b0;
        #20;
        for (int k = 1; k <= falls; k++) begin
            serial_clock = 1'b0;
            #HALF_NS;
            serial_clock = 1'b1;
            if (k <= 16) begin
                bits[16-k] = serial_result_out_line;
            end
            #HALF_NS;
            if (k == 13) begin
                #TRACK_GAP_NS;
            end
        end
        #8;
        frame_select_n = 1'b1;
        #60;
    endtask : run_frame
endmodule : host_link_model

`default_nettype wire

// >>> dv/serial_sar_adc_readout_bench.sv
// Purpose: Self-checking bench for the serial converter readout.
// Assumes: An ideal comparator holds vin steady through each frame.
// Notes:   A released pin reads inverted so a stale bit cannot pass.

`timescale 1ns/1ps
`default_nettype none

`define CHECK_EQ(name, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); end end

module serial_sar_adc_readout_bench;
    import adc_readout_pkg::*;

    logic clk;
    logic rst_n;
    wire logic serial_clock;
    wire logic frame_select_n;
    wire logic serial_result_out_line;
    wire logic comparator_high;
    logic serial_result_out;
    logic serial_result_oe_n;
    logic [RESULT_BITS-1:0] dac_code;
    logic sample_hold;
    logic analog_power_on;
    logic [RESULT_BITS-1:0] result_code;
    logic result_valid;
    logic result_dummy;
    logic [RESULT_BITS-1:0] vin;
    logic [15:0] bits;
    int miscompares = 0;
    int checks = 0;
    int valids = 0;

    // Pin level and ideal comparator.
    assign serial_result_out_line = serial_result_oe_n ^ serial_result_out;
    assign comparator_high = (vin >= dac_code);

    serial_sar_adc_readout u_dut (.clk(clk), .rst_n(rst_n), .serial_clock(serial_clock),
        .frame_select_n(frame_select_n), .serial_result_out(serial_result_out),
        .serial_result_oe_n(serial_result_oe_n), .comparator_high(comparator_high),
        .dac_code(dac_code), .sample_hold(sample_hold), .analog_power_on(analog_power_on),
        .result_code(result_code), .result_valid(result_valid), .result_dummy(result_dummy));

    host_link_model u_host (.serial_clock(serial_clock), .frame_select_n(frame_select_n),
        .serial_result_out_line(serial_result_out_line));

    // Count result pulses so each frame can be judged afterwards.
    always @(posedge clk) begin
        if (result_valid === 1'b1) begin
            valids <= valids + 1;
        end
    end

    task automatic frame(input int falls);
        u_host.run_frame(falls, bits);
        @(negedge clk);
    endtask : frame

    task automatic test_reset;
        `CHECK_EQ("oe_n", 1'b1, serial_result_oe_n)
        `CHECK_EQ("hold", 1'b0, sample_hold)
        `CHECK_EQ("power", 1'b0, analog_power_on)
        `CHECK_EQ("result", 8'h00, result_code)
        `CHECK_EQ("dummy", 1'b1, result_dummy)
        $display("test reset done");
    endtask : test_reset

    // First frame after reset wakes the core and yields no valid result.
    task automatic test_wake;
        int v0;
        vin = 8'h3C;
        v0 = valids;
        frame(16);
        `CHECK_EQ("power", 1'b1, analog_power_on)
        `CHECK_EQ("dummy", 1'b1, result_dummy)
        `CHECK_EQ("valid count", v0, valids)
        $display("test wake done");
    endtask : test_wake

    // Back-to-back frames at the code boundaries and at the A5 and 5A patterns.
    task automatic test_codes;
        logic [RESULT_BITS-1:0] codes [5] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01};
        int v0;
        foreach (codes[i]) begin
            vin = codes[i];
            v0 = valids;
            frame(16);
            `CHECK_EQ("frame bits", {2'b00, codes[i], 6'h00}, bits)
            `CHECK_EQ("result", codes[i], result_code)
            `CHECK_EQ("valid count", v0 + 1, valids)
            `CHECK_EQ("dummy", 1'b0, result_dummy)
            `CHECK_EQ("hold", 1'b0, sample_hold)
            `CHECK_EQ("oe_n", 1'b1, serial_result_oe_n)
        end
        $display("test codes done");
    endtask : test_codes

    // A noise pulse and a late abort both keep normal mode.
    task automatic test_noise_abort;
        int v0;
        vin = 8'hC3;
        v0 = valids;
        frame(1);
        `CHECK_EQ("power", 1'b1, analog_power_on)
        frame(12);
        `CHECK_EQ("cut bits", {2'b00, 8'hC3, 6'h00}, bits)
        `CHECK_EQ("power", 1'b1, analog_power_on)
        `CHECK_EQ("oe_n", 1'b1, serial_result_oe_n)
        `CHECK_EQ("valid count", v0, valids)
        $display("test noise and abort done");
    endtask : test_noise_abort

    // Shutdown entry, noise while asleep, a cut wake, then a full wake.
    task automatic test_shutdown;
        int v0;
        v0 = valids;
        frame(5);
        `CHECK_EQ("power", 1'b0, analog_power_on)
        frame(1);
        `CHECK_EQ("power", 1'b0, analog_power_on)
        #200;
        `CHECK_EQ("power", 1'b0, analog_power_on)
        frame(6);
        `CHECK_EQ("power", 1'b0, analog_power_on)
        frame(16);
        `CHECK_EQ("power", 1'b1, analog_power_on)
        `CHECK_EQ("dummy", 1'b1, result_dummy)
        `CHECK_EQ("valid count", v0, valids)
        vin = 8'h96;
        frame(16);
        `CHECK_EQ("result", 8'h96, result_code)
        `CHECK_EQ("dummy", 1'b0, result_dummy)
        `CHECK_EQ("valid count", v0 + 1, valids)
        $display("test shutdown done");
    endtask : test_shutdown

    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Main sequence; reset is held for four cycles with frame select high.
    initial begin
        rst_n = 1'b0;
        vin = 8'h00;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        test_reset;
        test_wake;
        test_codes;
        test_noise_abort;
        test_shutdown;
        give_verdict;
    end

    // Thirteen frames need about 5 us; this limit leaves wide margin.
    initial begin
        #50000;
        $display("watchdog expired");
        miscompares++;
        give_verdict;
    end
endmodule : serial_sar_adc_readout_bench

`default_nettype wire

// >>> rtl/adc_readout_pkg.sv
// Purpose: Shared constants and types for the serial converter readout block.
// Assumes: Edge numbers count serial clock edges after frame select falls.
// Notes:   Counts saturate, so long idle-low frames never wrap back.

package adc_readout_pkg;

    // Result width and the edge counter width.
    localparam int RESULT_BITS = 8;
    localparam int CNT_W = 5;

    // Edge numbers that steer the frame.
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam logic [CNT_W-1:0] FALL_NOISE_LIMIT = 5'h02;
    localparam logic [CNT_W-1:0] FALL_MODE_LIMIT = 5'h0A;
    localparam logic [CNT_W-1:0] FALL_FRAME_END = 5'h10;
    localparam logic [CNT_W-1:0] FALL_SAR_FIRST = 5'h02;
    localparam logic [CNT_W-1:0] FALL_DATA_FIRST = 5'h03;
    localparam logic [CNT_W-1:0] RISE_TRACK = 5'h0D;

    // Successive approximation starts with only the top trial bit set.
    localparam logic [RESULT_BITS-1:0] CODE_START = 8'h80;
    localparam logic [RESULT_BITS-1:0] CODE_ZERO = 8'h00;

    // Track interval the host must leave after the track edge, in ns and in cycles of clk.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TRACK_GAP_NS = 350;
    localparam int TRACK_GAP_CYC = (TRACK_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Power mode of the converter and progress of one frame.
    typedef enum logic {MODE_NORMAL, MODE_SHUTDOWN} mode_t;
    typedef enum logic [1:0] {FR_IDLE, FR_ACTIVE, FR_TAIL} frame_t;

endpackage : adc_readout_pkg

// >>> rtl/link_frame.sv
// Purpose: Serial clock side of the readout: edge counts, approximation, shift out.
// Assumes: The serial clock may stop whenever frame select is high.
// Notes:   Frame select high clears this logic, so every frame starts clean.

`timescale 1ns/1ps
`default_nettype none

module link_frame
    import adc_readout_pkg::*;
(
    // Link clock and framing.
    input wire logic serial_clock,
    input wire logic frame_select_n,
    // Analog comparator decision and trial code for the capacitor array.
    input wire logic comparator_high,
    output logic [RESULT_BITS-1:0] dac_code,
    // Serial data bit.
    output logic serial_result_out,
    // Frame progress levels for the system clock side.
    output logic past_noise,
    output logic past_mode,
    output logic frame_end,
    output logic track_seen
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [RESULT_BITS-1:0] code;
        logic data;
        logic past_noise;
        logic past_mode;
        logic frame_end;
    } fall_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic track;
    } rise_state_t;

    localparam fall_state_t FALL_RESET = '{cnt: CNT_ZERO, code: CODE_START, data: 1'b0,
                                           past_noise: 1'b0, past_mode: 1'b0,
                                           frame_end: 1'b0};
    localparam rise_state_t RISE_RESET = '{cnt: CNT_ZERO, track: 1'b0};

    fall_state_t fall_r;
    fall_state_t fall_nxt;
    rise_state_t rise_r;
    rise_state_t rise_nxt;

    // Falling edges number the frame, decide one bit each on edges 2 to 9 and launch the next bit.
    always_comb begin
        logic [CNT_W-1:0] edge_no;
        logic [CNT_W-1:0] sar_pos;
        logic [CNT_W-1:0] out_pos;
        edge_no = fall_r.cnt + 5'h01;
        sar_pos = edge_no - FALL_SAR_FIRST;
        out_pos = edge_no - FALL_DATA_FIRST;
        fall_nxt = fall_r;
        if (fall_r.cnt != CNT_MAX) begin
            fall_nxt.cnt = edge_no;
        end
        // Each decision keeps or drops the trial bit, giving straight binary.
        for (int b = 0; b < RESULT_BITS; b++) begin
            if (edge_no >= FALL_SAR_FIRST && sar_pos == CNT_W'(RESULT_BITS - 1 - b)) begin
                fall_nxt.code[b] = comparator_high;
            end
            if (edge_no >= FALL_SAR_FIRST && sar_pos == CNT_W'(RESULT_BITS - 2 - b)) begin
                fall_nxt.code[b] = 1'b1;
            end
        end
        // Leading zeros, result most significant first, then trailing zeros.
        fall_nxt.data = 1'b0;
        for (int b = 0; b < RESULT_BITS; b++) begin
            if (edge_no >= FALL_DATA_FIRST && out_pos == CNT_W'(RESULT_BITS - 1 - b)) begin
                fall_nxt.data = fall_r.code[b];
            end
        end
        fall_nxt.past_noise = fall_r.past_noise | (edge_no >= FALL_NOISE_LIMIT);
        fall_nxt.past_mode = fall_r.past_mode | (edge_no >= FALL_MODE_LIMIT);
        fall_nxt.frame_end = fall_r.frame_end | (edge_no >= FALL_FRAME_END);
    end

    // Frame select high holds the falling-edge side at its start point.
    always_ff @(negedge serial_clock or posedge frame_select_n) begin
        if (frame_select_n) begin
            fall_r <= FALL_RESET;
        end else begin
            fall_r <= fall_nxt;
        end
    end

    // Rising edges only mark the return to track.
    always_comb begin
        rise_nxt = rise_r;
        if (rise_r.cnt != CNT_MAX) begin
            rise_nxt.cnt = rise_r.cnt + 5'h01;
        end
        rise_nxt.track = rise_r.track | (rise_r.cnt + 5'h01 >= RISE_TRACK);
    end

    always_ff @(posedge serial_clock or posedge frame_select_n) begin
        if (frame_select_n) begin
            rise_r <= RISE_RESET;
        end else begin
            rise_r <= rise_nxt;
        end
    end

    assign dac_code = fall_r.code;
    assign serial_result_out = fall_r.data;
    assign past_noise = fall_r.past_noise;
    assign past_mode = fall_r.past_mode;
    assign frame_end = fall_r.frame_end;
    assign track_seen = rise_r.track;

endmodule : link_frame

`default_nettype wire

// >>> rtl/serial_sar_adc_readout.sv
// Purpose: Control and three-wire serial readout of an 8-bit approximation converter.
// Assumes: clk at 250 MHz; frame select and serial clock come from the host.
// Notes:   The serial clock side lives in link_frame; this file owns mode,
//          track/hold, output enable and the captured result.

`timescale 1ns/1ps
`default_nettype none

// Function
// - Frame select falling moves track to hold and starts a conversion frame.
// - Frame select falling starts driving the serial result pin.
// - Hold returns to track on the 13th rising serial clock edge.
// - Output floats after 16th falling edge or frame select rising, whichever first.
// - Frame is two zeros, eight result bits MSB first, six zeros.
// - Bits change on falling edges; host captures on the next rising edge.
// - Result is straight unsigned binary, one step equal to supply over 256.
// - Frame select low selects normal mode and begins a conversion.
// - Frame select rising after the 2nd but before the 10th falling edge enters shutdown.
// - Frame select held low past the 10th falling edge keeps normal mode.
// - Shutdown lasts until frame select is driven low again.
// - Serial clock sequences conversion and output; frame select frames each transfer.
// - Frame select rising before the 2nd falling edge keeps the current mode.
// - Rising between 10th and 16th falling edge: stay normal, abort, float output.
// - Waking frame cut before the 10th falling edge returns to shutdown.
module serial_sar_adc_readout
    import adc_readout_pkg::*;
(
    // System clock and synchronous reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host link: serial clock, frame select and the serial result pin.
    input wire logic serial_clock,
    input wire logic frame_select_n,
    output logic serial_result_out,
    output logic serial_result_oe_n,
    // Analog core: comparator in, trial code, hold switch and power.
    input wire logic comparator_high,
    output logic [RESULT_BITS-1:0] dac_code,
    output logic sample_hold,
    output logic analog_power_on,
    // Local copy of the finished result.
    output logic [RESULT_BITS-1:0] result_code,
    output logic result_valid,
    output logic result_dummy
);

    // Everything this module remembers.
    typedef struct packed {
        mode_t mode;
        mode_t start_mode;
        frame_t frame;
        logic cs_n_q;
        logic past_noise;
        logic past_mode;
        logic frame_end;
        logic track_seen;
        logic hold;
        logic oe_n;
        logic power_on;
        logic dummy;
        logic [RESULT_BITS-1:0] result;
        logic valid;
        logic result_dummy;
    } ctrl_state_t;

    // Power-up mode is unknown, so start in shutdown and treat the
    // first conversion as a dummy one.
    localparam ctrl_state_t CTRL_RESET = '{
        mode: MODE_SHUTDOWN,
        start_mode: MODE_SHUTDOWN,
        frame: FR_IDLE,
        cs_n_q: 1'b1,
        past_noise: 1'b0,
        past_mode: 1'b0,
        frame_end: 1'b0,
        track_seen: 1'b0,
        hold: 1'b0,
        oe_n: 1'b1,
        power_on: 1'b0,
        dummy: 1'b1,
        result: CODE_ZERO,
        valid: 1'b0,
        result_dummy: 1'b1
    };

    ctrl_state_t ctrl_r;
    ctrl_state_t ctrl_nxt;

    // Link side levels and their synchronised copies.
    logic link_past_noise;
    logic link_past_mode;
    logic link_frame_end;
    logic link_track_seen;
    logic cs_n_s;
    logic past_noise_s;
    logic past_mode_s;
    logic frame_end_s;
    logic track_seen_s;

    // Mode chosen when frame select rises, from how far the frame got.
    function automatic mode_t end_mode(input mode_t start, input logic noise_done,
                                       input logic mode_done);
        if (!noise_done) begin
            end_mode = start;
        end else if (!mode_done) begin
            end_mode = MODE_SHUTDOWN;
        end else begin
            end_mode = MODE_NORMAL;
        end
    endfunction : end_mode

    // The serial clock side: counts edges, runs the approximation and shifts bits.
    link_frame u_link (
        .serial_clock(serial_clock),
        .frame_select_n(frame_select_n),
        .comparator_high(comparator_high),
        .dac_code(dac_code),
        .serial_result_out(serial_result_out),
        .past_noise(link_past_noise),
        .past_mode(link_past_mode),
        .frame_end(link_frame_end),
        .track_seen(link_track_seen)
    );

    // Frame select and the link progress levels cross into clk through one
    // synchroniser bank, so they keep the same latency relative to each other.
    sync3 #(
        .W(5),
        .INIT(5'h10)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({frame_select_n, link_past_noise, link_past_mode, link_frame_end,
              link_track_seen}),
        .dout({cs_n_s, past_noise_s, past_mode_s, frame_end_s, track_seen_s})
    );

    // Frame sequencing, mode selection, track/hold and output enable.
    always_comb begin
        logic cs_fall;
        logic cs_rise;
        logic noise_done;
        logic mode_done;
        cs_fall = ctrl_r.cs_n_q & ~cs_n_s;
        cs_rise = ~ctrl_r.cs_n_q & cs_n_s;
        noise_done = ctrl_r.past_noise | past_noise_s;
        mode_done = ctrl_r.past_mode | past_mode_s;
        ctrl_nxt = ctrl_r;
        ctrl_nxt.cs_n_q = cs_n_s;
        ctrl_nxt.valid = 1'b0;
        case (ctrl_r.frame)
            FR_IDLE: begin
                // A new frame: sample, drive the pin and wake the analog core.
                if (cs_fall) begin
                    ctrl_nxt.frame = FR_ACTIVE;
                    ctrl_nxt.start_mode = ctrl_r.mode;
                    ctrl_nxt.mode = MODE_NORMAL;
                    ctrl_nxt.power_on = 1'b1;
                    ctrl_nxt.hold = 1'b1;
                    ctrl_nxt.oe_n = 1'b0;
                    // A frame that wakes the core cannot yield a usable result.
                    ctrl_nxt.dummy = (ctrl_r.mode == MODE_SHUTDOWN);
                    ctrl_nxt.past_noise = 1'b0;
                    ctrl_nxt.past_mode = 1'b0;
                    ctrl_nxt.frame_end = 1'b0;
                    ctrl_nxt.track_seen = 1'b0;
                end
            end
            FR_ACTIVE: begin
                // Progress is made sticky here because the link side clears
                // itself as soon as frame select rises.
                ctrl_nxt.past_noise = noise_done;
                ctrl_nxt.past_mode = mode_done;
                ctrl_nxt.frame_end = ctrl_r.frame_end | frame_end_s;
                ctrl_nxt.track_seen = ctrl_r.track_seen | track_seen_s;
                if (track_seen_s) begin
                    ctrl_nxt.hold = 1'b0;
                end
                // The code is complete once the last decision edge has passed.
                if (past_mode_s && !ctrl_r.past_mode) begin
                    ctrl_nxt.result = dac_code;
                    ctrl_nxt.result_dummy = ctrl_r.dummy;
                end
                if (frame_end_s) begin
                    ctrl_nxt.oe_n = 1'b1;
                    ctrl_nxt.hold = 1'b0;
                    ctrl_nxt.frame = FR_TAIL;
                    ctrl_nxt.valid = ~ctrl_r.dummy;
                end else if (cs_rise) begin
                    // Cut short: float the pin, drop back to track, pick the mode.
                    ctrl_nxt.oe_n = 1'b1;
                    ctrl_nxt.hold = 1'b0;
                    ctrl_nxt.frame = FR_IDLE;
                    ctrl_nxt.mode = end_mode(ctrl_r.start_mode, noise_done, mode_done);
                    ctrl_nxt.power_on = (ctrl_nxt.mode == MODE_NORMAL);
                    // Ending in shutdown or cutting a waking frame keeps the dummy flag set.
                    ctrl_nxt.dummy = ctrl_r.dummy | (ctrl_nxt.mode == MODE_SHUTDOWN);
                end
            end
            FR_TAIL: begin
                // Frame select idles low after the full word; wait for it to rise.
                if (cs_rise) begin
                    ctrl_nxt.frame = FR_IDLE;
                    ctrl_nxt.mode = MODE_NORMAL;
                    ctrl_nxt.power_on = 1'b1;
                    ctrl_nxt.dummy = 1'b0;
                end
            end
            default: begin
                ctrl_nxt.frame = FR_IDLE;
            end
        endcase
    end

    // One register stage for all control state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign serial_result_oe_n = ctrl_r.oe_n;
    assign sample_hold = ctrl_r.hold;
    assign analog_power_on = ctrl_r.power_on;
    assign result_code = ctrl_r.result;
    assign result_valid = ctrl_r.valid;
    assign result_dummy = ctrl_r.result_dummy;

endmodule : serial_sar_adc_readout

`default_nettype wire

// >>> rtl/sync3.sv
// Purpose: Three flip-flop synchroniser with a two-stage agreement filter.
// Assumes: Inputs are levels from another clock domain or a pin.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/1ps
`default_nettype none

module sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous levels in, filtered levels out.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t sync_r;
    sync_state_t sync_nxt;

    // A bit only changes once the second and third stages agree.
    always_comb begin
        sync_nxt = sync_r;
        sync_nxt.s1 = din;
        sync_nxt.s2 = sync_r.s1;
        sync_nxt.s3 = sync_r.s2;
        sync_nxt.q = (~(sync_r.s2 ^ sync_r.s3) & sync_r.s3)
                   | ((sync_r.s2 ^ sync_r.s3) & sync_r.q);
    end

    // Synchronous reset loads the idle level everywhere.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign dout = sync_r.q;

endmodule : sync3

`default_nettype wire
